// ### sec_defs.svh
// Purpose: Offsets, field positions and timing for the span error counters.
// Assumes: hclk at 50 MHz; one word per register on AHB-Lite.
// Notes: Counts above 4096 cycles are overridable module parameters.
// Operation
// - Four counters: line, path, sync, E-bit.
// - Update on second, 42ms, 62.5ms or manual.
// - Counters saturate, never wrap.
// - Shared port one second or manual input.
// - Same-polarity successive marks are bipolar violations.
// - Valid substitution codewords are not counted.
// - E1 select bit counts code violations instead.
// - Line counter ignores sync loss, saturates 65535.
// - T1 excessive zeros: 16 runs, 8 with B8ZS.
// - Path: ESF CRC-6 errors, D4 Ft errors.
// - D4 Fs errors counted when enabled.
// - T1 path counter paused during loss of frame.
// - E1 path counts CRC-4, paused on FAS/CRC-4 loss.
// - Each count read as high then low byte.
// - T1 multiframe mode counts unsynced multiframes always.
// - T1 F-bit mode counts Ft/FPS, paused on loss.
// - E1 sync counts FAS errors, paused while searching.
// - E1 CRC-4 E-bit zeros in frames 13, 15.
// - Loss of frame means framer lost alignment.
`ifndef SEC_DEFS_SVH
`define SEC_DEFS_SVH

`define SEC_CLK_NS      20
`define SEC_ONE_NS      1000000000
`define SEC_T1_NS       42000000
`define SEC_E1_NS       62500000
`define SEC_ONE_CYC     (`SEC_ONE_NS / `SEC_CLK_NS)
`define SEC_T1_CYC      (`SEC_T1_NS / `SEC_CLK_NS)
`define SEC_E1_CYC      (`SEC_E1_NS / `SEC_CLK_NS)

`define SEC_AW          8
`define SEC_OFF_CFG     8'h00
`define SEC_OFF_CTL     8'h04
`define SEC_OFF_UPD     8'h08
`define SEC_OFF_STAT    8'h0c
`define SEC_OFF_CNT     8'h10
`define SEC_OFF_END     8'h30

`define SEC_CFG_W       6
`define SEC_CFG_CV      0
`define SEC_CFG_FBIT    1
`define SEC_CFG_FS      2
`define SEC_CFG_SRC_LO  3
`define SEC_CFG_SRC_HI  4
`define SEC_CFG_SHARED  5
`define SEC_SRC_SEC     2'h0
`define SEC_SRC_INT     2'h1
`define SEC_SRC_MAN     2'h2

`define SEC_CTL_W       4
`define SEC_CTL_E1      0
`define SEC_CTL_ESF     1
`define SEC_CTL_ZCS     2
`define SEC_CTL_CRC4    3
`define SEC_UPD_GO      0

`define SEC_ZRUN_AMI    5'h10
`define SEC_ZRUN_ZCS    5'h08
`define SEC_EFRAME_A    4'hd
`define SEC_EFRAME_B    4'hf
`define SEC_CNT_MAX     16'hffff
`define SEC_CNT_LINE    0
`define SEC_CNT_PATH    1
`define SEC_CNT_SYNC    2
`define SEC_CNT_EBIT    3

`endif

// ### sec_pkg.sv
// Purpose: Types shared by the span error counters.
// Assumes: sec_defs.svh gives the numbers.
// Notes: State is held as one packed struct.
package sec_pkg;

   typedef enum logic {SEC_PH_IDLE, SEC_PH_WR} sec_phase_t;

   // One received bit from the line decoder.
   typedef struct packed {
      logic valid;
      logic pos;
      logic neg;
      logic subst;
   } sec_line_t;

   // One-cycle error and framing events from the framer.
   typedef struct packed {
      logic       crc6_err;
      logic       ft_err;
      logic       fs_err;
      logic       fps_err;
      logic       crc4_err;
      logic       fas_err;
      logic       mframe_end;
      logic       ebit_stb;
      logic       ebit;
      logic [3:0] ebit_frame;
   } sec_evt_t;

   // Synchronizer levels from the framer.
   typedef struct packed {
      logic receive_loss_of_frame;
      logic multiframe_unsynced;
      logic fas_lost;
      logic crc4_lost;
      logic fas_search;
      logic cas_search;
      logic crc4_search;
   } sec_stat_t;

   typedef struct packed {
      sec_phase_t       phase;
      logic [7:0]       waddr;
      logic [5:0]       cfg;
      logic [3:0]       ctl;
      logic [31:0]      rdata;
      logic             rdy;
      logic             resp;
      logic             have_mark;
      logic             last_pos;
      logic             have_bpv;
      logic             last_bpv_pos;
      logic [4:0]       zrun;
      logic [31:0]      sec_timer;
      logic [31:0]      int_timer;
      logic             sec_tick;
      logic             upd;
      logic [3:0][15:0] run;
      logic [3:0][15:0] hold;
   } sec_state_t;

endpackage

// ### sec_counters.sv
// Purpose: Four saturating error counters of one receive span.
// Assumes: Framer and decoder events are synchronous to hclk.
// Notes: Register reads answer with zero wait states.
//
// The implementer's own choices: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ps
`include "sec_defs.svh"
module sec_counters #(
   parameter int ONE_SEC_CYC = `SEC_ONE_CYC,
   parameter int T1_INT_CYC  = `SEC_T1_CYC,
   parameter int E1_INT_CYC  = `SEC_E1_CYC
) (
   // Clock and reset.
   input  wire logic              hclk,
   input  wire logic              hresetn,
   // AHB-Lite slave.
   input  wire logic              hsel,
   input  wire logic [31:0]       haddr,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic [2:0]        hsize,
   input  wire logic [31:0]       hwdata,
   input  wire logic              hready,
   output logic                   hreadyout,
   output logic [31:0]            hrdata,
   output logic                   hresp,
   // Framer and line decoder.
   input  wire sec_pkg::sec_line_t line_in,
   input  wire sec_pkg::sec_evt_t  evt_in,
   input  wire sec_pkg::sec_stat_t stat_in,
   // Update sources and indications.
   input  wire logic              shared_sec_in,
   input  wire logic              manual_update_in,
   output logic                   sec_tick_out,
   output logic                   update_out
);

   localparam logic [31:0] ONE_LIM = 32'(ONE_SEC_CYC - 1);
   localparam logic [31:0] T1_LIM  = 32'(T1_INT_CYC - 1);
   localparam logic [31:0] E1_LIM  = 32'(E1_INT_CYC - 1);

   sec_pkg::sec_state_t st_q;
   sec_pkg::sec_state_t st_d;

   logic       addr_ok;
   logic       upd_write;
   logic       e1;
   logic       mark;
   logic       bpv;
   logic       bpv_cnt;
   logic       cv;
   logic       ez;
   logic [4:0] zthr;
   logic       sec_wrap;
   logic       int_wrap;
   logic       upd_evt;
   logic [3:0] inc;

   function automatic logic [15:0] sec_sat(input logic [15:0] v,
                                           input logic        up);
      sec_sat = (up && v != `SEC_CNT_MAX) ? v + 16'h0001 : v;
   endfunction

   function automatic logic [31:0] sec_read(input sec_pkg::sec_state_t s,
                                            input sec_pkg::sec_stat_t  f,
                                            input logic [7:0]          a);
      logic [1:0] idx;
      idx      = 2'((a - `SEC_OFF_CNT) >> 3);
      sec_read = 32'h0000_0000;
      if (a == `SEC_OFF_CFG) begin
         sec_read = {26'h000_0000, s.cfg};
      end else if (a == `SEC_OFF_CTL) begin
         sec_read = {28'h000_0000, s.ctl};
      end else if (a == `SEC_OFF_STAT) begin
         sec_read = {20'h0_0000, s.zrun, f};
      end else if (a >= `SEC_OFF_CNT && a < `SEC_OFF_END) begin
         // High byte first, then low byte of the latched count.
         if (a[2]) begin
            sec_read = {24'h00_0000, s.hold[idx][7:0]};
         end else begin
            sec_read = {24'h00_0000, s.hold[idx][15:8]};
         end
      end
   endfunction

   always_comb begin
      st_d          = st_q;
      st_d.upd      = 1'b0;
      st_d.sec_tick = 1'b0;
      st_d.rdy      = 1'b1;
      st_d.resp     = 1'b0;
      st_d.phase    = sec_pkg::SEC_PH_IDLE;
      upd_write     = 1'b0;
      addr_ok       = hsel && htrans[1] && hready;

      // Write data phase; the write lands at the end of it.
      if (st_q.phase == sec_pkg::SEC_PH_WR) begin
         case (st_q.waddr)
            `SEC_OFF_CFG: begin
               st_d.cfg = hwdata[`SEC_CFG_W-1:0];
            end
            `SEC_OFF_CTL: begin
               st_d.ctl = hwdata[`SEC_CTL_W-1:0];
            end
            `SEC_OFF_UPD: begin
               upd_write = hwdata[`SEC_UPD_GO];
            end
            default: begin
            end
         endcase
      end
      if (addr_ok) begin
         if (hwrite) begin
            st_d.phase = sec_pkg::SEC_PH_WR;
            st_d.waddr = haddr[`SEC_AW-1:0];
         end else begin
            st_d.rdata = sec_read(st_q, stat_in, haddr[`SEC_AW-1:0]);
         end
      end

      e1 = st_q.ctl[`SEC_CTL_E1];

      // Line: polarity of the last mark and of the last violation.
      mark    = line_in.valid && (line_in.pos || line_in.neg);
      bpv     = mark && st_q.have_mark &&
                (line_in.pos == st_q.last_pos);
      bpv_cnt = bpv && !(st_q.ctl[`SEC_CTL_ZCS] && line_in.subst);
      cv      = bpv && st_q.have_bpv &&
                (line_in.pos == st_q.last_bpv_pos);
      if (mark) begin
         st_d.have_mark = 1'b1;
         st_d.last_pos  = line_in.pos;
      end
      if (bpv) begin
         st_d.have_bpv     = 1'b1;
         st_d.last_bpv_pos = line_in.pos;
      end

      // A zero run is counted once, when it reaches the threshold.
      zthr = st_q.ctl[`SEC_CTL_ZCS] ? `SEC_ZRUN_ZCS : `SEC_ZRUN_AMI;
      ez   = 1'b0;
      if (line_in.valid && !mark) begin
         // A run left above a lowered threshold must not wrap and recount.
         if (st_q.zrun < zthr) begin
            st_d.zrun = st_q.zrun + 5'h01;
            ez        = !e1 && st_q.cfg[`SEC_CFG_CV] &&
                        (st_q.zrun == zthr - 5'h01);
         end
      end else if (mark) begin
         st_d.zrun = 5'h00;
      end

      // Line counter runs regardless of sync state.
      if (e1) begin
         inc[`SEC_CNT_LINE] = st_q.cfg[`SEC_CFG_CV] ? cv : bpv_cnt;
      end else begin
         inc[`SEC_CNT_LINE] = bpv_cnt || ez;
      end

      // Path counter.
      if (e1) begin
         inc[`SEC_CNT_PATH] = evt_in.crc4_err && !stat_in.fas_lost &&
                              !stat_in.crc4_lost;
      end else if (st_q.ctl[`SEC_CTL_ESF]) begin
         inc[`SEC_CNT_PATH] = evt_in.crc6_err &&
                              !stat_in.receive_loss_of_frame;
      end else begin
         inc[`SEC_CNT_PATH] = (evt_in.ft_err ||
                               (evt_in.fs_err && st_q.cfg[`SEC_CFG_FS])) &&
                              !stat_in.receive_loss_of_frame;
      end

      // Sync counter.
      if (e1) begin
         inc[`SEC_CNT_SYNC] = evt_in.fas_err &&
                              !stat_in.receive_loss_of_frame &&
                              !stat_in.fas_search && !stat_in.cas_search &&
                              !stat_in.crc4_search;
      end else if (st_q.cfg[`SEC_CFG_FBIT]) begin
         inc[`SEC_CNT_SYNC] = (st_q.ctl[`SEC_CTL_ESF] ? evt_in.fps_err
                                                       : evt_in.ft_err) &&
                              !stat_in.receive_loss_of_frame;
      end else begin
         inc[`SEC_CNT_SYNC] = evt_in.mframe_end &&
                              stat_in.multiframe_unsynced;
      end

      // Far-end block errors, E1 CRC-4 multiframe only.
      inc[`SEC_CNT_EBIT] = e1 && st_q.ctl[`SEC_CTL_CRC4] &&
                           evt_in.ebit_stb && !evt_in.ebit &&
                           (evt_in.ebit_frame == `SEC_EFRAME_A ||
                            evt_in.ebit_frame == `SEC_EFRAME_B) &&
                           !stat_in.fas_lost &&
                           !stat_in.crc4_lost;

      // Own one-second timer, exported for sharing by other spans.
      sec_wrap = (st_q.sec_timer == ONE_LIM);
      st_d.sec_timer = sec_wrap ? 32'h0000_0000
                                : st_q.sec_timer + 32'h0000_0001;
      st_d.sec_tick = sec_wrap;

      // Short interval follows the line mode.
      int_wrap = (st_q.int_timer == (e1 ? E1_LIM : T1_LIM)) ||
                 (st_q.int_timer > (e1 ? E1_LIM : T1_LIM));
      st_d.int_timer = int_wrap ? 32'h0000_0000
                                : st_q.int_timer + 32'h0000_0001;

      case (st_q.cfg[`SEC_CFG_SRC_HI:`SEC_CFG_SRC_LO])
         `SEC_SRC_SEC: begin
            upd_evt = st_q.cfg[`SEC_CFG_SHARED] ? shared_sec_in
                                                : sec_wrap;
         end
         `SEC_SRC_INT: begin
            upd_evt = int_wrap;
         end
         `SEC_SRC_MAN: begin
            upd_evt = manual_update_in || upd_write;
         end
         default: begin
            upd_evt = 1'b0;
         end
      endcase

      // An event in the update cycle goes into the latched value.
      for (int i = 0; i < 4; i++) begin
         if (upd_evt) begin
            st_d.hold[i] = sec_sat(st_q.run[i], inc[i]);
            st_d.run[i]  = 16'h0000;
         end else begin
            st_d.run[i] = sec_sat(st_q.run[i], inc[i]);
         end
      end
      st_d.upd = upd_evt;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_q     <= '0;
         st_q.rdy <= 1'b1;
      end else begin
         st_q <= st_d;
      end
   end

   assign hreadyout    = st_q.rdy;
   assign hrdata       = st_q.rdata;
   assign hresp        = st_q.resp;
   assign sec_tick_out = st_q.sec_tick;
   assign update_out   = st_q.upd;

   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   property p_sat_hold;
      (st_q.run[`SEC_CNT_LINE] == `SEC_CNT_MAX) && !upd_evt
         |=> st_q.run[`SEC_CNT_LINE] == `SEC_CNT_MAX;
   endproperty
   a_sat_hold: assert property (p_sat_hold)
      else $error("Line counter left its maximum without an update.");

   property p_bpv_count;
      bpv && !line_in.subst && !e1 && !upd_evt &&
      (st_q.run[`SEC_CNT_LINE] != `SEC_CNT_MAX)
         |=> st_q.run[`SEC_CNT_LINE] ==
             $past(st_q.run[`SEC_CNT_LINE]) + 16'h0001;
   endproperty
   a_bpv_count: assert property (p_bpv_count)
      else $error("Bipolar violation was not counted.");

   property p_codeword;
      line_in.subst && st_q.ctl[`SEC_CTL_ZCS] && !e1 && line_in.valid &&
      !upd_evt && !(line_in.valid && !mark)
         |=> st_q.run[`SEC_CNT_LINE] == $past(st_q.run[`SEC_CNT_LINE]);
   endproperty
   a_codeword: assert property (p_codeword)
      else $error("Substitution codeword was counted.");

   property p_t1_lof;
      !e1 && stat_in.receive_loss_of_frame && !upd_evt
         |=> $stable(st_q.run[`SEC_CNT_PATH]);
   endproperty
   a_t1_lof: assert property (p_t1_lof)
      else $error("Path counter moved during loss of frame.");

   property p_e1_path;
      e1 && (stat_in.fas_lost || stat_in.crc4_lost) && !upd_evt
         |=> $stable(st_q.run[`SEC_CNT_PATH]);
   endproperty
   a_e1_path: assert property (p_e1_path)
      else $error("Path counter moved during E1 sync loss.");

   property p_e1_sync;
      e1 && (stat_in.fas_search || stat_in.cas_search) && !upd_evt
         |=> $stable(st_q.run[`SEC_CNT_SYNC]);
   endproperty
   a_e1_sync: assert property (p_e1_sync)
      else $error("Sync counter moved during alignment search.");

   property p_ebit_frame;
      evt_in.ebit_stb && (evt_in.ebit_frame != `SEC_EFRAME_A) &&
      (evt_in.ebit_frame != `SEC_EFRAME_B) && !upd_evt
         |=> $stable(st_q.run[`SEC_CNT_EBIT]);
   endproperty
   a_ebit_frame: assert property (p_ebit_frame)
      else $error("E-bit counted outside frames 13 and 15.");

   property p_update;
      upd_evt |=> update_out && (st_q.run == '0) &&
                  (st_q.hold[`SEC_CNT_PATH] ==
                   sec_sat($past(st_q.run[`SEC_CNT_PATH]),
                           $past(inc[`SEC_CNT_PATH])))
                  ##1 !update_out || $past(upd_evt);
   endproperty
   a_update: assert property (p_update)
      else $error("Update did not latch and clear the counts.");

   property p_manual;
      (st_q.cfg[`SEC_CFG_SRC_HI:`SEC_CFG_SRC_LO] == `SEC_SRC_MAN) &&
      !manual_update_in && !upd_write
         |=> !update_out;
   endproperty
   a_manual: assert property (p_manual)
      else $error("Manual mode updated without a request.");

   property p_hold_steady;
      !upd_evt |=> $stable(st_q.hold);
   endproperty
   a_hold_steady: assert property (p_hold_steady)
      else $error("Latched counts changed without an update.");

endmodule

// ### sec_framer_model.sv
// Purpose: Behavioural framer and line decoder of one receive span.
// Assumes: Tasks are entered just after a rising edge of hclk.
// Notes: Idle line bits carry the inverse of the last bit sent.
`timescale 1ns/1ps
module sec_framer_model (
   // Clock.
   input  wire logic          hclk,
   // Toward the counters.
   output sec_pkg::sec_line_t line_in,
   output sec_pkg::sec_evt_t  evt_in,
   output sec_pkg::sec_stat_t stat_in
);
   initial begin
      line_in = '0;
      evt_in = '0;
      stat_in = '0;
   end

   // Mark code m is 1 for positive, 2 for negative, 0 for a zero.
   task automatic bits(input logic [1:0] m, input logic s, input int n);
      line_in <= {1'b1, m[0], m[1], s};
      repeat (n) @(posedge hclk);
   endtask

   // Stale values would hide a decoder that ignores the valid flag.
   task automatic rest();
      line_in <= {1'b0, ~line_in.pos, ~line_in.neg, ~line_in.subst};
      @(posedge hclk);
   endtask

   task automatic ev(input logic [12:0] e, input int n);
      repeat (n) begin
         evt_in <= e;
         @(posedge hclk);
         evt_in <= '0;
         @(posedge hclk);
      end
   endtask

   task automatic st(input logic [6:0] v);
      stat_in <= v;
      @(posedge hclk);
   endtask
endmodule

// ### tb_span_error_counters.sv
// Purpose: Self-checking bench for the span error counters.
// Assumes: Zero wait-state slave; shortened timer parameters.
// Notes: Line expectations come from a bench model of the coding rules.
`timescale 1ns/1ps
module tb_span_error_counters;
   localparam int OSC = 100;
   localparam int T1C = 20;
   localparam int E1C = 30;
   localparam logic [12:0] CRC6 = 13'h1000, FT = 13'h0800, FS = 13'h0400;
   localparam logic [12:0] FPS = 13'h0200, CRC4 = 13'h0100;
   localparam logic [12:0] FAS = 13'h0080, MFE = 13'h0040;

   logic               hclk;
   logic               hresetn;
   logic               hsel;
   logic [31:0]        haddr;
   logic [1:0]         htrans;
   logic               hwrite;
   logic [2:0]         hsize;
   logic [31:0]        hwdata;
   logic               hreadyout;
   logic [31:0]        hrdata;
   logic               hresp;
   sec_pkg::sec_line_t line_in;
   sec_pkg::sec_evt_t  evt_in;
   sec_pkg::sec_stat_t stat_in;
   logic               shared_sec_in;
   logic               manual_update_in;
   logic               sec_tick_out;
   logic               update_out;
   int                 error_cnt = 0;
   int                 check_count = 0;
   int                 seed = 32'h0000_1da2;
   int                 cyc = 0;
   int                 xl = 0;
   int                 zr = 0;
   logic [1:0]         lm = '0;
   logic [1:0]         lb = '0;
   logic               e1 = 1'b0;
   logic               x0 = 1'b0;
   logic               zcs = 1'b0;

   sec_counters #(.ONE_SEC_CYC(OSC), .T1_INT_CYC(T1C), .E1_INT_CYC(E1C))
   i_sec_counters (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hrdata(hrdata), .hresp(hresp), .line_in(line_in), .evt_in(evt_in),
      .stat_in(stat_in), .shared_sec_in(shared_sec_in),
      .manual_update_in(manual_update_in), .sec_tick_out(sec_tick_out),
      .update_out(update_out));

   sec_framer_model i_sec_framer_model (.hclk(hclk), .line_in(line_in),
      .evt_in(evt_in), .stat_in(stat_in));

   task automatic close_out();
      if (error_cnt == 0 && check_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e) begin
         error_cnt++;
         $display("MISMATCH %0t got %h exp %h", $time, g, e);
      end
   endtask

   task automatic ahb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r);
      htrans <= 2'b10;
      hwrite <= w;
      // Upper address bits are random: only the low byte may decode.
      haddr <= {24'($random(seed)), a};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      r = hrdata;
      chk(hresp, '0);
   endtask

   task automatic mode(input logic [5:0] c, input logic [3:0] t);
      logic [31:0] r;
      ahb(1'b1, 8'h00, 32'(c), r);
      ahb(1'b1, 8'h04, 32'(t), r);
      x0 = c[0];
      e1 = t[0];
      zcs = t[2];
   endtask

   // Expected line increment for one received bit in the current mode.
   function automatic int lx(input logic [1:0] m, input logic s);
      int r = 0;
      if (m == 2'd0) begin
         zr++;
         if (!e1 && x0 && zr == (zcs ? 8 : 16)) r = 1;
      end else begin
         zr = 0;
         if (m == lm) begin
            if (!(s && zcs)) r = (e1 && x0) ? int'(m == lb) : 1;
            lb = m;
         end
         lm = m;
      end
      return r;
   endfunction

   task automatic mk(input logic [1:0] m, input logic s, input int n);
      repeat (n) xl += lx(m, s);
      i_sec_framer_model.bits(m, s, n);
   endtask

   task automatic rnd(input int n);
      repeat (n) mk(2'({$random(seed)} % 3), 1'b0, 1);
      i_sec_framer_model.rest();
   endtask

   // Manual update, then both bytes of all four latched counts.
   task automatic snap(input logic [15:0] p, input logic [15:0] s,
                       input logic [15:0] e);
      logic [31:0] r;
      logic [15:0] x [4];
      x = '{(xl > 65535) ? 16'hffff : 16'(xl), p, s, e};
      xl = 0;
      ahb(1'b1, 8'h08, 32'h0000_0001, r);
      for (int i = 0; i < 4; i++) begin
         ahb(1'b0, 8'(8'h10 + 8 * i), '0, r);
         chk(r, 32'(x[i][15:8]));
         ahb(1'b0, 8'(8'h14 + 8 * i), '0, r);
         chk(r, 32'(x[i][7:0]));
      end
   endtask

   task automatic gap(input logic t, input int p);
      int n = 0;
      // Pulses are sampled mid-cycle, away from the edge that launches them.
      do @(negedge hclk); while ((t ? sec_tick_out : update_out) !== 1'b1);
      do begin
         @(negedge hclk);
         n++;
      end while ((t ? sec_tick_out : update_out) !== 1'b1);
      @(posedge hclk);
      chk(n, p);
   endtask

   task automatic kick(input logic sh);
      if (sh) shared_sec_in <= 1'b1;
      else manual_update_in <= 1'b1;
      @(posedge hclk);
      shared_sec_in <= 1'b0;
      manual_update_in <= 1'b0;
      @(negedge hclk);
      chk(update_out, 32'h0000_0001);
      @(posedge hclk);
   endtask

   initial begin
      hclk = 1'b0;
      forever #10 hclk = ~hclk;
   end

   always @(posedge hclk) begin
      cyc++;
      if (cyc == 80000) begin
         error_cnt++;
         close_out();
      end
   end

   initial begin
      logic [31:0] r;
      logic [7:0]  ra [6];
      ra = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h30};
      hresetn <= 1'b0;
      hsel <= 1'b1;
      haddr <= '0;
      htrans <= '0;
      hwrite <= 1'b0;
      hsize <= 3'h2;
      hwdata <= '0;
      shared_sec_in <= 1'b0;
      manual_update_in <= 1'b0;
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      ahb(1'b1, 8'h30, 32'hffff_ffff, r);
      ahb(1'b1, 8'h10, 32'hffff_ffff, r);
      for (int i = 0; i < 6; i++) begin
         ahb(1'b0, ra[i], '0, r);
         chk(r, '0);
      end
      // A write while deselected must leave the configuration alone.
      hsel <= 1'b0;
      ahb(1'b1, 8'h00, 32'h0000_003f, r);
      hsel <= 1'b1;
      ahb(1'b0, 8'h00, '0, r);
      chk(r, '0);
      mode(6'h10, 4'h0);
      rnd(64);
      i_sec_framer_model.ev(FT, 3);
      i_sec_framer_model.st(7'h60);
      i_sec_framer_model.ev(FT, 2);
      i_sec_framer_model.ev(MFE, 2);
      i_sec_framer_model.ev(13'h002d, 1);
      i_sec_framer_model.st(7'h00);
      snap(3, 2, 0);
      snap(0, 0, 0);
      for (int z = 0; z < 2; z++) begin
         mode(6'h11, 4'(z * 4));
         mk(2'd1, 1'b0, 1);
         mk(2'd0, 1'b0, 20);
         mk(2'd2, 1'b0, 1);
         mk(2'd2, 1'b1, 1);
         i_sec_framer_model.rest();
         snap(0, 0, 0);
      end
      mode(6'h16, 4'h0);
      i_sec_framer_model.ev(FT, 1);
      i_sec_framer_model.ev(FS, 2);
      i_sec_framer_model.st(7'h40);
      i_sec_framer_model.ev(FT, 1);
      i_sec_framer_model.st(7'h00);
      snap(3, 1, 0);
      mode(6'h16, 4'h2);
      i_sec_framer_model.ev(CRC6, 2);
      i_sec_framer_model.ev(FPS | FS | FT, 1);
      snap(2, 1, 0);
      mode(6'h11, 4'hd);
      rnd(64);
      i_sec_framer_model.ev(CRC4 | FAS, 2);
      i_sec_framer_model.ev(13'h002d, 1);
      i_sec_framer_model.ev(13'h002f, 1);
      i_sec_framer_model.ev(13'h002e, 1);
      i_sec_framer_model.ev(13'h003d, 1);
      i_sec_framer_model.st(7'h02);
      i_sec_framer_model.ev(CRC4 | FAS, 1);
      i_sec_framer_model.st(7'h04);
      i_sec_framer_model.ev(FAS, 1);
      i_sec_framer_model.st(7'h08);
      i_sec_framer_model.ev(CRC4 | 13'h002d, 1);
      i_sec_framer_model.st(7'h50);
      i_sec_framer_model.ev(CRC4 | FAS | 13'h002f, 1);
      i_sec_framer_model.st(7'h00);
      snap(3, 2, 2);
      mode(6'h08, 4'h0);
      gap(1'b0, T1C);
      mode(6'h08, 4'h1);
      gap(1'b0, E1C);
      mode(6'h00, 4'h1);
      gap(1'b1, OSC);
      gap(1'b0, OSC);
      mode(6'h20, 4'h1);
      kick(1'b1);
      mode(6'h10, 4'h0);
      kick(1'b0);
      i_sec_framer_model.st(7'h50);
      mk(2'd1, 1'b0, 65540);
      i_sec_framer_model.rest();
      i_sec_framer_model.st(7'h00);
      snap(0, 0, 0);
      close_out();
   end
endmodule
